// file: rtl/dtos_pkg.sv
// Package for the transmit overhead source selector.
// Assumes a 40 MHz system clock and a Wishbone bus with byte addressing.
package dtos_pkg;

	// Register indices; byte address is four times the index.
	localparam logic [13:0] IDX_TEST  = 14'h110c;
	localparam logic [13:0] IDX_MASK1 = 14'h1136;
	localparam logic [13:0] IDX_MASK2 = 14'h1137;
	localparam logic [13:0] IDX_MASK3 = 14'h1138;
	localparam logic [13:0] IDX_MASK4 = 14'h1139;
	localparam logic [13:0] IDX_FCNT  = 14'h113a;

	// Test register field positions.
	localparam int TST_OHSRC    = 7;
	localparam int TST_RX_GAP   = 6;
	localparam int TST_TX_GAP   = 5;
	localparam int TST_RX_LOCK  = 4;
	localparam int TST_RX_PRBS  = 3;
	localparam int TST_TX_PRBS  = 2;

	// Reset values and writable masks.
	localparam logic [7:0] TEST_RST  = 8'h00;
	localparam logic [7:0] TEST_WMSK = 8'hec;
	localparam logic [7:0] MASK_RST  = 8'hff;
	localparam logic [7:0] MASK1_RST = 8'h0f;
	localparam logic [7:0] MASK1_WMSK = 8'h0f;

	// Frame geometry.
	localparam int BLOCK_BITS   = 85;
	localparam int SF_BLOCKS    = 8;
	localparam int SUBFRAMES    = 7;
	localparam int FRAME_BITS   = 4760;
	localparam int PAYLOAD_BITS = 4704;
	localparam int OH_BITS      = 56;

	// Line bit pacing.
	localparam int CLK_PERIOD_NS = 25;
	localparam int BIT_TIME_NS   = 50;
	localparam int TICK_CYCLES   = (BIT_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
		BIT_TIME_NS / CLK_PERIOD_NS;

	// Input buffer shape.
	localparam int FIFO_DEPTH = 8;
	localparam int WORD_W     = 2;

	// One bit of the incoming stream with its frame marker.
	typedef struct packed {
		logic sync;
		logic data;
	} dtos_word_t;

	// One bit of the outbound line stream.
	typedef struct packed {
		logic strobe;
		logic start;
		logic data;
	} dtos_line_t;

endpackage

// file: rtl/dtos_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module dtos_fifo #(
	parameter int WIDTH = 2,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_in,    // System clock.
	input  wire logic             rst_n_in,  // Asynchronous reset, active low.
	input  wire logic             s_valid_in, // Write side valid.
	output logic                  s_ready_out, // Write side ready.
	input  wire logic [WIDTH-1:0] s_data_in, // Write data.
	output logic                  m_valid_out, // Read side valid.
	input  wire logic             m_ready_in, // Read side ready.
	output logic [WIDTH-1:0]      m_data_out // Read data.
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	// Flags come straight from the fill count.
	assign s_ready_out = (count != (AW+1)'(DEPTH));
	assign m_valid_out = (count != '0);
	assign push        = s_valid_in & s_ready_out;
	assign pop         = m_valid_out & m_ready_in;
	assign m_data_out  = mem[rd_ptr];

	// Storage is written only on an accepted push.
	always_ff @(posedge clk_in)
	begin
		if (push)
			mem[wr_ptr] <= s_data_in;
	end

	// Pointers wrap at the depth.
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
		end
	end

	// Fill count tracks push and pop together.
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			count <= '0;
		else if (push && !pop)
			count <= count + 1'b1;
		else if (pop && !push)
			count <= count - 1'b1;
	end

endmodule

// file: rtl/dtos_top.sv
// Transmit overhead source selector: builds the outbound frame bit by bit.
// Assumes a Wishbone classic master and a serial payload source with
// valid/ready and a frame marker on the first bit of each frame.
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// [RULE1] Test register bit 7 enables the payload stream as overhead source.
// [RULE2] When enabled, selected overhead bits are copied from the input stream.
// [RULE3] Mask 1 bits 1-3 cover C71-C73; bits 7-4 read zero.
// [RULE4] Mask 2 covers C51-C53 at bits 1-3, C61-C63 at 5-7.
// [RULE5] Mask 3 covers C31-C33 at bits 1-3, C41-C43 at 5-7.
// [RULE6] Mask 4: X1 bit 0, C11-C13 bits 1-3, X2 bit 4, C21-C23 5-7.
// [RULE7] Source enabled and masks zero pass all C-bits unchanged.
// [RULE8] A frame is 4760 bits, 56 overhead; only overhead is selectable.
// [RULE9] Test register also holds gapped-clock, PRBS enables and lock status.
// [RULE10] A mask bit of one forces internal generation of that bit.
// [RULE11] After reset and with source off, all overhead is internal.
// [RULE12] Position counter decodes overhead slots and selects in one cycle.
module dtos_top
	import dtos_pkg::*;
(
	input  wire logic        REF_CLK_IN,       // 40 MHz system clock.
	input  wire logic        RST_N_IN,         // Asynchronous reset, active low.
	input  wire logic [15:0] WB_ADR_IN,        // Byte address.
	input  wire logic [31:0] WB_DAT_IN,        // Write data.
	output logic      [31:0] WB_DAT_OUT,       // Read data.
	input  wire logic        WB_WE_IN,         // Write enable.
	input  wire logic [3:0]  WB_SEL_IN,        // Byte selects.
	input  wire logic        WB_STB_IN,        // Strobe.
	input  wire logic        WB_CYC_IN,        // Cycle.
	output logic             WB_ACK_OUT,       // Acknowledge.
	input  wire logic        PAY_DATA_IN,      // Serial input bit.
	input  wire logic        PAY_SYNC_IN,      // First bit of a frame.
	input  wire logic        PAY_VALID_IN,     // Input bit valid.
	output logic             PAY_READY_OUT,    // Input buffer has room.
	input  wire logic        RX_PRBS_LOCK_IN,  // Receive PRBS lock status.
	output logic             RX_GAP_EN_OUT,    // Receive gapped clock enable.
	output logic             TX_GAP_EN_OUT,    // Transmit gapped clock enable.
	output logic             RX_PRBS_EN_OUT,   // Receive PRBS detector enable.
	output logic             TX_PRBS_EN_OUT,   // Transmit PRBS generator enable.
	output logic             LINE_DATA_OUT,    // Outbound line bit.
	output logic             LINE_STROBE_OUT,  // Outbound bit valid pulse.
	output logic             LINE_START_OUT    // Outbound first bit of frame.
);

	// Returns the mask bit governing an overhead slot; one means internal.
	function automatic logic mask_of(
		input logic [2:0] sf,
		input logic [2:0] blk,
		input logic [7:0] m1,
		input logic [7:0] m2,
		input logic [7:0] m3,
		input logic [7:0] m4
	);
		logic [7:0] reg_sel;
		logic [2:0] bit_sel;
		reg_sel = 8'hff;
		bit_sel = 3'h0;
		mask_of = 1'b1;
		if (blk == 3'h0)
		begin
			if (sf == 3'h0)
				mask_of = m4[0];
			else if (sf == 3'h1)
				mask_of = m4[4];
		end
		else if (blk[0] == 1'b0)
		begin
			case (sf[2:1])
				2'h0: reg_sel = m4;
				2'h1: reg_sel = m3;
				2'h2: reg_sel = m2;
				default: reg_sel = m1;
			endcase
			bit_sel = {sf[0], blk[2:1]};
			mask_of = reg_sel[bit_sel];
		end
	endfunction

	// Returns the internally generated value of an overhead slot.
	function automatic logic int_bit(
		input logic [2:0] sf,
		input logic [2:0] blk,
		input logic       par
	);
		int_bit = 1'b1;
		case (blk)
			3'h0:
			begin
				case (sf)
					3'h2, 3'h3: int_bit = par;
					3'h4, 3'h6: int_bit = 1'b0;
					default: int_bit = 1'b1;
				endcase
			end
			3'h1, 3'h7: int_bit = 1'b1;
			3'h3, 3'h5: int_bit = 1'b0;
			default: int_bit = (sf == 3'h2) ? par : 1'b1;
		endcase
	endfunction

	logic [7:0]  test_reg;
	logic [7:0]  mask1;
	logic [7:0]  mask2;
	logic [7:0]  mask3;
	logic [7:0]  mask4;
	logic [7:0]  frame_cnt;
	logic        ack;
	logic [31:0] rd_data;
	logic [13:0] idx;
	logic        access;
	logic        wr_en;
	logic [7:0]  wdata;
	logic [7:0]  rd_mux;

	logic [$clog2(TICK_CYCLES+1)-1:0] div_cnt;
	logic        tick;

	dtos_word_t  in_word;
	dtos_word_t  fo_word;
	logic        fo_valid;
	logic        slot;

	logic [2:0]  sf_cnt;
	logic [2:0]  blk_cnt;
	logic [6:0]  bit_cnt;
	logic [2:0]  eff_sf;
	logic [2:0]  eff_blk;
	logic [6:0]  eff_bit;
	logic        is_oh;
	logic        use_ext;
	logic        out_bit;
	logic        at_first;
	logic        at_last;
	logic        par_acc;
	logic        par;
	dtos_line_t  line;

	// Bus decode; the register word index sits above the byte lanes.
	assign idx    = WB_ADR_IN[15:2];
	assign access = WB_CYC_IN & WB_STB_IN & ~ack;
	assign wr_en  = access & WB_WE_IN & WB_SEL_IN[0];
	assign wdata  = WB_DAT_IN[7:0];

	// Read multiplexer; unmapped words read as zero.
	always_comb
	begin
		case (idx)
			IDX_TEST:  rd_mux = {test_reg[7:5], RX_PRBS_LOCK_IN,
				test_reg[3:2], 2'h0}; // see [RULE9]
			IDX_MASK1: rd_mux = mask1 & MASK1_WMSK; // see [RULE3]
			IDX_MASK2: rd_mux = mask2;
			IDX_MASK3: rd_mux = mask3;
			IDX_MASK4: rd_mux = mask4;
			IDX_FCNT:  rd_mux = frame_cnt;
			default:   rd_mux = 8'h00;
		endcase
	end

	// Every access is answered one cycle after it is seen, mapped or not.
	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
			ack <= 1'b0;
		else
			ack <= access;
	end

	// Read data is captured when the access is accepted.
	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
			rd_data <= 32'h0000_0000;
		else if (access)
			rd_data <= {24'h00_0000, rd_mux};
	end

	assign WB_ACK_OUT = ack;
	assign WB_DAT_OUT = rd_data;

	// Test register; source select starts off so overhead is internal.
	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
			test_reg <= TEST_RST; // see [RULE11]
		else if (wr_en && idx == IDX_TEST)
			test_reg <= wdata & TEST_WMSK; // see [RULE1] see [RULE9]
	end

	// Mask registers; reset leaves every overhead bit internal.
	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			mask1 <= MASK1_RST;
			mask2 <= MASK_RST;
			mask3 <= MASK_RST;
			mask4 <= MASK_RST;
		end
		else if (wr_en)
		begin
			if (idx == IDX_MASK1)
				mask1 <= wdata & MASK1_WMSK; // see [RULE3]
			if (idx == IDX_MASK2)
				mask2 <= wdata; // see [RULE4]
			if (idx == IDX_MASK3)
				mask3 <= wdata; // see [RULE5]
			if (idx == IDX_MASK4)
				mask4 <= wdata; // see [RULE6]
		end
	end

	// Control outputs follow the test register.
	assign RX_GAP_EN_OUT  = test_reg[TST_RX_GAP];
	assign TX_GAP_EN_OUT  = test_reg[TST_TX_GAP];
	assign RX_PRBS_EN_OUT = test_reg[TST_RX_PRBS];
	assign TX_PRBS_EN_OUT = test_reg[TST_TX_PRBS];

	// Bit-rate divider gives one enable pulse per line bit time.
	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
			div_cnt <= '0;
		else if (tick)
			div_cnt <= '0;
		else
			div_cnt <= div_cnt + 1'b1;
	end

	assign tick = (div_cnt == ($bits(div_cnt))'(TICK_CYCLES - 1));

	// Input buffer; the line side drains it one bit per tick.
	assign in_word.sync = PAY_SYNC_IN;
	assign in_word.data = PAY_DATA_IN;

	dtos_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_in      (REF_CLK_IN),
		.rst_n_in    (RST_N_IN),
		.s_valid_in  (PAY_VALID_IN),
		.s_ready_out (PAY_READY_OUT),
		.s_data_in   (in_word),
		.m_valid_out (fo_valid),
		.m_ready_in  (tick),
		.m_data_out  (fo_word)
	);

	// A bit slot happens only when a bit is waiting; an empty buffer gaps.
	assign slot = tick & fo_valid;

	// A frame marker realigns the position to the first bit.
	assign eff_sf   = fo_word.sync ? 3'h0 : sf_cnt;
	assign eff_blk  = fo_word.sync ? 3'h0 : blk_cnt;
	assign eff_bit  = fo_word.sync ? 7'h00 : bit_cnt;
	assign at_first = (eff_sf == 3'h0) && (eff_blk == 3'h0) && (eff_bit == 7'h00);
	assign at_last  = (eff_sf == 3'(SUBFRAMES - 1)) &&
		(eff_blk == 3'(SF_BLOCKS - 1)) && (eff_bit == 7'(BLOCK_BITS - 1));

	// Only the first bit of each 85-bit block is overhead.
	assign is_oh = (eff_bit == 7'h00); // see [RULE8] see [RULE12]

	// External insertion needs the source select on and the mask bit clear.
	assign use_ext = test_reg[TST_OHSRC] &
		~mask_of(eff_sf, eff_blk, mask1, mask2, mask3, mask4); // see [RULE10] see [RULE12]

	// Payload passes through; overhead picks its source in the same cycle.
	always_comb
	begin
		if (!is_oh)
			out_bit = fo_word.data;
		else if (use_ext)
			out_bit = fo_word.data; // see [RULE2] see [RULE7]
		else
			out_bit = int_bit(eff_sf, eff_blk, par); // see [RULE11]
	end

	// Position counters: bits in a block, blocks in a subframe, subframes.
	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			sf_cnt  <= 3'h0;
			blk_cnt <= 3'h0;
			bit_cnt <= 7'h00;
		end
		else if (slot)
		begin
			if (eff_bit != 7'(BLOCK_BITS - 1))
			begin
				sf_cnt  <= eff_sf;
				blk_cnt <= eff_blk;
				bit_cnt <= eff_bit + 1'b1;
			end
			else
			begin
				bit_cnt <= 7'h00;
				if (eff_blk != 3'(SF_BLOCKS - 1))
				begin
					sf_cnt  <= eff_sf;
					blk_cnt <= eff_blk + 1'b1;
				end
				else
				begin
					blk_cnt <= 3'h0;
					sf_cnt  <= at_last ? 3'h0 : eff_sf + 1'b1; // see [RULE8]
				end
			end
		end
	end

	// Even parity over the payload of a frame goes into the next frame.
	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			par_acc <= 1'b0;
			par     <= 1'b0;
		end
		else if (slot)
		begin
			if (at_last)
			begin
				par     <= par_acc ^ out_bit;
				par_acc <= 1'b0;
			end
			else if (at_first)
				par_acc <= 1'b0;
			else if (!is_oh)
				par_acc <= par_acc ^ out_bit;
		end
	end

	// Completed outbound frames, readable for software.
	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
			frame_cnt <= 8'h00;
		else if (slot && at_last)
			frame_cnt <= frame_cnt + 1'b1;
	end

	// Registered line output; the strobe marks each new bit.
	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
			line <= '0;
		else
		begin
			line.strobe <= slot;
			if (slot)
			begin
				line.start <= at_first;
				line.data  <= out_bit;
			end
		end
	end

	assign LINE_DATA_OUT   = line.data;
	assign LINE_STROBE_OUT = line.strobe;
	assign LINE_START_OUT  = line.start;

endmodule

// file: dv/dtos_top_properties.sv
// Checker for the transmit overhead source selector top module.
// Assumes it is bound to dtos_top and sees only that module's ports.
`timescale 1ns/1ps
module dtos_top_props
	import dtos_pkg::*;
(
	input logic        REF_CLK_IN,      // Clock.
	input logic        RST_N_IN,        // Reset, active low.
	input logic [15:0] WB_ADR_IN,       // Byte address.
	input logic [31:0] WB_DAT_IN,       // Write data.
	input logic [31:0] WB_DAT_OUT,      // Read data.
	input logic        WB_WE_IN,        // Write enable.
	input logic [3:0]  WB_SEL_IN,       // Byte selects.
	input logic        WB_STB_IN,       // Strobe.
	input logic        WB_CYC_IN,       // Cycle.
	input logic        WB_ACK_OUT,      // Acknowledge.
	input logic        RX_PRBS_LOCK_IN, // Lock status.
	input logic        TX_GAP_EN_OUT,   // Gapped clock enable.
	input logic        LINE_DATA_OUT,   // Line bit.
	input logic        LINE_STROBE_OUT, // Line strobe.
	input logic        LINE_START_OUT   // Frame start.
);
	default clocking cb @(posedge REF_CLK_IN);
	endclocking
	default disable iff (!RST_N_IN);
	logic        req;
	logic [13:0] idx;
	int          cnt;
	logic        seen;
	// A new bus request and the word index it addresses.
	assign req = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
	assign idx = WB_ADR_IN[15:2];
	// Position of the last line bit, counted from the last frame start.
	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			cnt <= 0;
			seen <= 1'b0;
		end
		else if (LINE_STROBE_OUT)
		begin
			cnt <= LINE_START_OUT ? 0 : cnt + 1;
			seen <= seen || LINE_START_OUT;
		end
	end
	a_ack_after_req: assert property (req |=> WB_ACK_OUT)
		else $error("ack missing after request");
	a_ack_single: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
		else $error("ack longer than one cycle");
	a_ack_has_cause: assert property (WB_ACK_OUT |-> $past(req))
		else $error("ack without request");
	a_read_high_zero: assert property (WB_ACK_OUT |-> WB_DAT_OUT[31:8] == 24'h0)
		else $error("upper read data not zero");
	a_gap_en_write: assert property (req && WB_WE_IN && WB_SEL_IN[0] && idx == IDX_TEST
		|=> TX_GAP_EN_OUT == $past(WB_DAT_IN[TST_TX_GAP])) else $error("gap enable not written");
	a_lock_read_live: assert property (req && !WB_WE_IN && idx == IDX_TEST
		|=> WB_DAT_OUT[TST_RX_LOCK] == $past(RX_PRBS_LOCK_IN) && WB_DAT_OUT[1:0] == 2'h0)
		else $error("test register read wrong");
	a_mask1_upper_zero: assert property (req && !WB_WE_IN && idx == IDX_MASK1
		|=> WB_DAT_OUT[7:4] == 4'h0) else $error("mask 1 upper bits not zero");
	a_strobe_spaced: assert property (LINE_STROBE_OUT |=> !LINE_STROBE_OUT)
		else $error("line strobes too close");
	a_line_holds: assert property (!LINE_STROBE_OUT |-> $stable(LINE_DATA_OUT)
		&& $stable(LINE_START_OUT)) else $error("line changed without strobe");
	a_frame_length: assert property (LINE_STROBE_OUT && seen
		|-> LINE_START_OUT == (cnt == FRAME_BITS - 1)) else $error("frame length wrong");
	c_start: cover property (LINE_STROBE_OUT && LINE_START_OUT);
	c_test_write: cover property (req && WB_WE_IN && idx == IDX_TEST);
	c_mask_read: cover property (req && !WB_WE_IN && idx == IDX_MASK1);
endmodule
bind dtos_top dtos_top_props dtos_top_props_inst (.REF_CLK_IN(REF_CLK_IN),
	.RST_N_IN(RST_N_IN), .WB_ADR_IN(WB_ADR_IN), .WB_DAT_IN(WB_DAT_IN), .WB_DAT_OUT(WB_DAT_OUT),
	.WB_WE_IN(WB_WE_IN), .WB_SEL_IN(WB_SEL_IN), .WB_STB_IN(WB_STB_IN), .WB_CYC_IN(WB_CYC_IN),
	.WB_ACK_OUT(WB_ACK_OUT), .RX_PRBS_LOCK_IN(RX_PRBS_LOCK_IN), .TX_GAP_EN_OUT(TX_GAP_EN_OUT),
	.LINE_DATA_OUT(LINE_DATA_OUT), .LINE_STROBE_OUT(LINE_STROBE_OUT),
	.LINE_START_OUT(LINE_START_OUT));

// file: dv/dtos_pay_source.sv
// Model of the terminal equipment feeding the payload input, one frame per go pulse.
// Assumes the selector's valid/ready input and one clock.
`timescale 1ns/1ps
module dtos_pay_source
	import dtos_pkg::*;
(
	input  wire logic clk_in,     // Clock.
	input  wire logic rst_n_in,   // Reset, active low.
	input  wire logic go_in,      // Start one frame.
	input  wire logic slow_in,    // Offer a bit only every fourth cycle.
	input  wire logic ext_val_in, // Value placed in every overhead slot.
	input  wire logic ready_in,   // Buffer has room.
	output logic      valid_out,  // Bit offered.
	output dtos_word_t word_out   // Bit and frame marker.
);
	int         pos;
	logic       busy;
	logic [1:0] gap;
	// Payload bits follow a fixed pattern; overhead slots carry the chosen value.
	function automatic logic bit_at(int p);
		return (p % BLOCK_BITS == 0) ? ext_val_in : p[0] ^ p[3];
	endfunction
	// Offers bits in order, holds each until taken, inverts the line once released.
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			pos <= 0;
			busy <= 1'b0;
			valid_out <= 1'b0;
			word_out <= '0;
			gap <= 2'h0;
		end
		else
		begin
			gap <= gap + 2'h1;
			if (go_in)
			begin
				pos <= 0;
				busy <= 1'b1;
			end
			else if (valid_out && ready_in)
			begin
				pos <= pos + 1;
				busy <= (pos != FRAME_BITS - 1);
				if (pos == FRAME_BITS - 1 || slow_in)
				begin
					valid_out <= 1'b0;
					word_out <= {1'b0, ~word_out.data};
				end
				else
					word_out <= {1'b0, bit_at(pos + 1)};
			end
			else if (!valid_out && busy && (!slow_in || gap == 2'h0))
			begin
				valid_out <= 1'b1;
				word_out <= {pos == 0, bit_at(pos)};
			end
		end
	end
endmodule

// file: dv/testbench.sv
// Self-checking bench for the transmit overhead source selector.
// Assumes dtos_top, its bound checker and the payload source model.
`timescale 1ns/1ps
module testbench
	import dtos_pkg::*;
	;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [15:0] adr = 16'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic [7:0]  rd;
	logic        we = 1'b0;
	logic [3:0]  sel = 4'h0;
	logic        stb = 1'b0;
	logic        cyc = 1'b0;
	logic        ack;
	logic        lock = 1'b0;
	logic        go = 1'b0;
	logic        slow = 1'b0;
	logic        ev = 1'b0;
	logic        rdy, ldat, lstb, lst, pvalid, rxg, txg, rxp, txp;
	logic        seen_full = 1'b0;
	logic        par_run = 1'b0;
	logic        par_exp = 1'b0;
	logic [2:0]  e;
	dtos_word_t  word;
	logic [7:0]  sh [1:4] = '{8'h0f, 8'hff, 8'hff, 8'hff};
	logic [7:0]  sh_test = 8'h00;
	int          n_mismatch = 0;
	int          compares = 0;
	int          cycles = 0;
	int          mpos = 0;
	int          nstrobe = 0;
	dtos_top dtos_top_inst (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .WB_ADR_IN(adr),
		.WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_WE_IN(we), .WB_SEL_IN(sel), .WB_STB_IN(stb),
		.WB_CYC_IN(cyc), .WB_ACK_OUT(ack), .PAY_DATA_IN(word.data), .PAY_SYNC_IN(word.sync),
		.PAY_VALID_IN(pvalid), .PAY_READY_OUT(rdy), .RX_PRBS_LOCK_IN(lock), .RX_GAP_EN_OUT(rxg),
		.TX_GAP_EN_OUT(txg), .RX_PRBS_EN_OUT(rxp), .TX_PRBS_EN_OUT(txp), .LINE_DATA_OUT(ldat),
		.LINE_STROBE_OUT(lstb), .LINE_START_OUT(lst));
	dtos_pay_source dtos_pay_source_inst (.clk_in(clk), .rst_n_in(rst_n), .go_in(go),
		.slow_in(slow), .ext_val_in(ev), .ready_in(rdy), .valid_out(pvalid), .word_out(word));
	// Clock at 40 MHz.
	initial
	begin
		forever #12.5 clk = ~clk;
	end
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// One classic Wishbone cycle, held until ack is sampled high.
	task automatic wb(input logic w, input logic [13:0] idx, input logic [7:0] d,
		input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		adr <= {idx, 2'b00};
		we <= w;
		wdat <= {24'h0, d};
		sel <= s;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		if (n >= 20)
			check("ack", 8'h0, 8'h1);
		rd = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic rd_chk(input string what, input logic [13:0] idx, input logic [7:0] exp);
		wb(1'b0, idx, 8'h00, 4'hf);
		check(what, rd, exp);
	endtask
	task automatic cfg(input logic [7:0] t, m4, m3, m2, m1);
		wb(1'b1, IDX_TEST, t, 4'h1);
		wb(1'b1, IDX_MASK4, m4, 4'h1);
		wb(1'b1, IDX_MASK3, m3, 4'h1);
		wb(1'b1, IDX_MASK2, m2, 4'h1);
		wb(1'b1, IDX_MASK1, m1, 4'h1);
		sh_test = t & TEST_WMSK;
		sh = '{m1 & MASK1_WMSK, m2, m3, m4};
	endtask
	// Sends one frame and waits until all of its bits have left the line side.
	task automatic run_frame(input logic s, input logic v);
		int tgt;
		tgt = nstrobe + FRAME_BITS;
		@(posedge clk);
		slow <= s;
		ev <= v;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		while (nstrobe < tgt)
			@(posedge clk);
	endtask
	// Returns checkable, external and value for an overhead slot.
	function automatic logic [2:0] exp_oh(int p);
		int   sf;
		int   blk;
		int   k;
		logic ext;
		sf = p / (BLOCK_BITS * SF_BLOCKS);
		blk = (p % (BLOCK_BITS * SF_BLOCKS)) / BLOCK_BITS;
		k = (blk % 2 == 0) ? blk / 2 : 0;
		ext = sh_test[TST_OHSRC] && !sh[4 - sf / 2][k + 4 * (sf % 2)];
		if (blk % 2 == 1)
			return {2'b10, blk == 1 || blk == 7};
		if (blk == 0 && sf >= 4)
			return {2'b10, sf == 5};
		if (blk == 0 && sf >= 2)
			return 3'b000;
		if (ext)
			return {2'b11, ev};
		return (sf == 2) ? 3'b000 : 3'b101;
	endfunction
	// Judges every outbound bit against its frame position; also bounds the run.
	always @(posedge clk)
	begin
		if (lstb === 1'b1)
		begin
			e = exp_oh(mpos);
			check("start", lst, mpos == 0);
			// Payload parity of each frame is expected in the next frame's P and CP slots.
			if (mpos % BLOCK_BITS != 0)
			begin
				check("payload", ldat, mpos[0] ^ mpos[3]);
				par_run = par_run ^ mpos[0] ^ mpos[3];
			end
			else if (e[1])
				check("external", ldat, e[0]);
			else if (e[2])
				check("internal", ldat, e[0]);
			else
				check("parity", ldat, par_exp);
			if (mpos == FRAME_BITS - 1)
			begin
				par_exp = par_run;
				par_run = 1'b0;
			end
			mpos = (mpos == FRAME_BITS - 1) ? 0 : mpos + 1;
			nstrobe++;
		end
		if (rdy === 1'b0)
			seen_full = 1'b1;
		cycles++;
		if (cycles > 90000)
		begin
			n_mismatch++;
			end_of_test();
		end
	end
	task automatic t_reset();
		rd_chk("test", IDX_TEST, 8'h00);
		rd_chk("mask1", IDX_MASK1, 8'h0f);
		rd_chk("mask2", IDX_MASK2, 8'hff);
		rd_chk("mask3", IDX_MASK3, 8'hff);
		rd_chk("mask4", IDX_MASK4, 8'hff);
		run_frame(1'b0, 1'b0);
		$display("reset test done");
	endtask
	task automatic t_test_reg();
		lock <= 1'b1;
		wb(1'b1, IDX_TEST, 8'hff, 4'h1);
		rd_chk("test set", IDX_TEST, 8'hfc);
		check("enables", {rxg, txg, rxp, txp}, 8'h0f);
		wb(1'b1, IDX_TEST, 8'h00, 4'he);
		rd_chk("test nosel", IDX_TEST, 8'hfc);
		wb(1'b1, IDX_TEST, 8'h00, 4'h1);
		rd_chk("test clear", IDX_TEST, 8'h10);
		lock <= 1'b0;
		wb(1'b1, 14'h1200, 8'hff, 4'h1);
		rd_chk("unmapped", 14'h1200, 8'h00);
		$display("test register test done");
	endtask
	task automatic t_masks();
		wb(1'b1, IDX_MASK1, 8'hff, 4'h1);
		rd_chk("mask1 ro", IDX_MASK1, 8'h0f);
		for (int i = 0; i < 3; i++)
		begin
			wb(1'b1, IDX_MASK2 + 14'(i), 8'ha5, 4'h1);
			rd_chk("mask rw", IDX_MASK2 + 14'(i), 8'ha5);
		end
		$display("mask test done");
	endtask
	task automatic t_frames();
		cfg(8'h80, 8'h00, 8'h00, 8'h00, 8'h00);
		run_frame(1'b1, 1'b0);
		$display("external slow frame done");
		seen_full = 1'b0;
		cfg(8'h80, 8'h0f, 8'hf0, 8'h0f, 8'h0a);
		run_frame(1'b0, 1'b0);
		check("buffer full", seen_full, 8'h01);
		$display("mixed mask frame done");
		cfg(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
		run_frame(1'b0, 1'b0);
		rd_chk("frames", IDX_FCNT, 8'h04);
		$display("source off frame done");
	endtask
	// Main sequence.
	initial
	begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_test_reg();
		t_masks();
		t_frames();
		end_of_test();
	end
endmodule
